// ### bio_port_regs.svh
// Register offsets, reset values and field layout of the I/O port block.
`ifndef BIO_PORT_REGS_SVH
`define BIO_PORT_REGS_SVH
// ************************************************************
// File addresses
// ************************************************************
`define BIO_NARROW_PORT_ADDR 5'h05
`define BIO_WIDE_ONE_ADDR 5'h06
`define BIO_WIDE_TWO_ADDR 5'h07
// ************************************************************
// Fields and reset values
// ************************************************************
`define BIO_NARROW_PORT_MSB 3
`define BIO_NARROW_PORT_WIDTH 4
`define BIO_DIRECTION_RESET 8'hff
`define BIO_NARROW_UNUSED_READ 4'h0
`endif

// ### bio_port_pkg.sv
// Types shared by the I/O port block.
package bio_port_pkg;
  typedef logic [7:0] bio_byte_t;
  typedef logic [4:0] bio_addr_t;
  typedef logic [3:0] bio_nib_t;
endpackage

// ### bio_ports.sv
// Three general-purpose I/O ports with write-only direction registers.
`timescale 1ns/1ps
`include "bio_port_regs.svh"
// ************************************************************
// Port block
// ************************************************************
module bio_ports #(
  parameter bit WIDE_TWO_IS_PORT = 1'b1
) (
  input  wire logic                    sys_clk_in,
  input  wire logic                    sys_rst_in,
  input  wire bio_port_pkg::bio_addr_t file_addr_in,
  input  wire logic                    file_rd_in,
  input  wire logic                    file_wr_in,
  input  wire bio_port_pkg::bio_byte_t file_wdata_in,
  input  wire logic                    direction_load_op_in,
  input  wire bio_port_pkg::bio_addr_t direction_sel_in,
  input  wire bio_port_pkg::bio_byte_t accum_in,
  output logic                         file_hit_out,
  output bio_port_pkg::bio_byte_t      file_rdata_out,
  input  wire bio_port_pkg::bio_nib_t  narrow_port_pins_in,
  output bio_port_pkg::bio_nib_t       narrow_port_pins_out,
  output bio_port_pkg::bio_nib_t       narrow_port_pins_oe_out,
  input  wire bio_port_pkg::bio_byte_t wide_one_pin_bit_in,
  output bio_port_pkg::bio_byte_t      wide_one_pin_bit_out,
  output bio_port_pkg::bio_byte_t      wide_one_pin_bit_oe_out,
  input  wire bio_port_pkg::bio_byte_t wide_two_pin_bit_in,
  output bio_port_pkg::bio_byte_t      wide_two_pin_bit_out,
  output bio_port_pkg::bio_byte_t      wide_two_pin_bit_oe_out
);
  import bio_port_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Two stages before any read; reads therefore see the pins two clocks late.
  bio_nib_t  narrow_meta_reg;
  bio_nib_t  narrow_sync_reg;
  bio_byte_t wide_one_meta_reg;
  bio_byte_t wide_one_sync_reg;
  bio_byte_t wide_two_meta_reg;
  bio_byte_t wide_two_sync_reg;

  always_ff @(posedge sys_clk_in) begin
    narrow_meta_reg   <= narrow_port_pins_in;
    narrow_sync_reg   <= narrow_meta_reg;
    wide_one_meta_reg <= wide_one_pin_bit_in;
    wide_one_sync_reg <= wide_one_meta_reg;
    wide_two_meta_reg <= wide_two_pin_bit_in;
    wide_two_sync_reg <= wide_two_meta_reg;
  end

  // ************************************************************
  // Data latches and direction registers
  // ************************************************************
  bio_nib_t  narrow_latch_reg;
  bio_nib_t  narrow_latch_next;
  bio_byte_t wide_one_latch_reg;
  bio_byte_t wide_one_latch_next;
  bio_byte_t wide_two_latch_reg;
  bio_byte_t wide_two_latch_next;
  bio_byte_t narrow_port_direction_reg;
  bio_byte_t narrow_port_direction_next;
  bio_byte_t wide_one_direction_reg;
  bio_byte_t wide_one_direction_next;
  bio_byte_t wide_two_direction_reg;
  bio_byte_t wide_two_direction_next;
  bio_byte_t rdata_next;
  logic      hit_next;
  bio_nib_t  narrow_pins_next;
  bio_nib_t  narrow_oe_next;
  bio_byte_t narrow_enable;
  bio_byte_t wide_one_pins_next;
  bio_byte_t wide_one_oe_next;
  bio_byte_t wide_two_pins_next;
  bio_byte_t wide_two_oe_next;

  function automatic logic addr_is(input bio_addr_t a, input bio_addr_t b);
    addr_is = (a == b);
  endfunction

  // A one in a direction bit leaves that pin undriven.
  function automatic bio_byte_t drive_enable(input bio_byte_t dir);
    drive_enable = ~dir;
  endfunction

  always_comb begin
    narrow_latch_next   = narrow_latch_reg;
    wide_one_latch_next = wide_one_latch_reg;
    wide_two_latch_next = wide_two_latch_reg;
    if (file_wr_in) begin
      // Every bit is written even for input pins, so it shows later.
      if (addr_is(file_addr_in, `BIO_NARROW_PORT_ADDR)) begin
        narrow_latch_next =
          file_wdata_in[`BIO_NARROW_PORT_MSB:0];
      end
      if (addr_is(file_addr_in, `BIO_WIDE_ONE_ADDR)) begin
        wide_one_latch_next = file_wdata_in;
      end
      if (addr_is(file_addr_in, `BIO_WIDE_TWO_ADDR)) begin
        wide_two_latch_next = file_wdata_in;
      end
    end
  end

  always_comb begin
    narrow_port_direction_next = narrow_port_direction_reg;
    wide_one_direction_next    = wide_one_direction_reg;
    wide_two_direction_next    = wide_two_direction_reg;
    if (sys_rst_in) begin
      narrow_port_direction_next = `BIO_DIRECTION_RESET;
      wide_one_direction_next    = `BIO_DIRECTION_RESET;
      wide_two_direction_next    = `BIO_DIRECTION_RESET;
    end else if (direction_load_op_in) begin
      // Whole accumulator copied; each bit governs at most one pin.
      if (addr_is(direction_sel_in, `BIO_NARROW_PORT_ADDR)) begin
        narrow_port_direction_next = accum_in;
      end
      if (addr_is(direction_sel_in, `BIO_WIDE_ONE_ADDR)) begin
        wide_one_direction_next = accum_in;
      end
      if (addr_is(direction_sel_in, `BIO_WIDE_TWO_ADDR)) begin
        wide_two_direction_next = accum_in;
      end
    end
  end

  // Latches take no reset so master-clear and watchdog leave them alone.
  always_ff @(posedge sys_clk_in) begin
    narrow_latch_reg   <= narrow_latch_next;
    wide_one_latch_reg <= wide_one_latch_next;
    wide_two_latch_reg <= wide_two_latch_next;
  end

  always_ff @(posedge sys_clk_in) begin
    narrow_port_direction_reg <= narrow_port_direction_next;
    wide_one_direction_reg    <= wide_one_direction_next;
    wide_two_direction_reg    <= wide_two_direction_next;
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Direction registers have no read decode at all.
  always_comb begin
    rdata_next = 8'h00;
    hit_next   = 1'b0;
    if (file_rd_in && !sys_rst_in) begin
      case (file_addr_in)
        `BIO_NARROW_PORT_ADDR: begin
          rdata_next = {`BIO_NARROW_UNUSED_READ, narrow_sync_reg};
          hit_next   = 1'b1;
        end
        `BIO_WIDE_ONE_ADDR: begin
          rdata_next = wide_one_sync_reg;
          hit_next   = 1'b1;
        end
        `BIO_WIDE_TWO_ADDR: begin
          // Storage variant has no pins, so its latch is what reads back.
          rdata_next = WIDE_TWO_IS_PORT ? wide_two_sync_reg
                                        : wide_two_latch_reg;
          hit_next   = 1'b1;
        end
        default: begin
          rdata_next = 8'h00;
          hit_next   = 1'b0;
        end
      endcase
    end
  end

  // Reset is folded into the next values, so this stage only copies.
  always_ff @(posedge sys_clk_in) begin
    file_rdata_out <= rdata_next;
    file_hit_out   <= hit_next;
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  // Enables come from the next-state so drivers drop in the reset cycle.
  always_comb begin
    narrow_pins_next   = narrow_latch_next;
    narrow_enable      = drive_enable(narrow_port_direction_next);
    narrow_oe_next     = narrow_enable[`BIO_NARROW_PORT_MSB:0];
    wide_one_pins_next = wide_one_latch_next;
    wide_one_oe_next   = drive_enable(wide_one_direction_next);
    wide_two_pins_next = wide_two_latch_next;
    wide_two_oe_next   = 8'h00;
    if (WIDE_TWO_IS_PORT) begin
      wide_two_oe_next = drive_enable(wide_two_direction_next);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    narrow_port_pins_out    <= narrow_pins_next;
    narrow_port_pins_oe_out <= narrow_oe_next;
    wide_one_pin_bit_out    <= wide_one_pins_next;
    wide_one_pin_bit_oe_out <= wide_one_oe_next;
    wide_two_pin_bit_out    <= wide_two_pins_next;
    wide_two_pin_bit_oe_out <= wide_two_oe_next;
  end
endmodule

// ### bio_ext_model.sv
// Outside circuits that share the port pins with the block.
`timescale 1ns/1ps
// ****
// Pin partner
// ****
module bio_ext_model (
  input  wire logic [19:0] dev_in,
  input  wire logic [19:0] oe_in,
  input  wire logic [19:0] ext_in,
  output logic      [19:0] level_out
);
  // Outside levels are held by the bench until read, never latched here.
  assign level_out = (dev_in & oe_in) | (ext_in & ~oe_in);
endmodule

// ### bio_ports_monitor.sv
// Concurrent checks on the ports of the I/O port block.
`timescale 1ns/1ps
// ****
// Checker
// ****
module bio_ports_monitor (
  input wire logic                    sys_clk_in,
  input wire logic                    sys_rst_in,
  input wire bio_port_pkg::bio_addr_t file_addr_in,
  input wire logic                    file_rd_in,
  input wire logic                    direction_load_op_in,
  input wire bio_port_pkg::bio_addr_t direction_sel_in,
  input wire bio_port_pkg::bio_byte_t accum_in,
  input wire logic                    file_hit_out,
  input wire bio_port_pkg::bio_byte_t file_rdata_out,
  input wire bio_port_pkg::bio_nib_t  narrow_port_pins_oe_out,
  input wire bio_port_pkg::bio_byte_t wide_one_pin_bit_in,
  input wire bio_port_pkg::bio_byte_t wide_one_pin_bit_oe_out,
  input wire bio_port_pkg::bio_byte_t wide_two_pin_bit_oe_out
);
  logic mapped;
  logic dl1;
  assign mapped = file_addr_in inside {5'h05, 5'h06, 5'h07};
  assign dl1 = direction_load_op_in && direction_sel_in == 5'h06;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_RST_OE: assert property (
    $fell(sys_rst_in) |-> {narrow_port_pins_oe_out, wide_one_pin_bit_oe_out,
    wide_two_pin_bit_oe_out} == 20'h00000) else $error("Driver on at reset.");
  AST_UNMAPPED: assert property (
    file_rd_in && !mapped |=> !file_hit_out && file_rdata_out == 8'h00)
    else $error("Unmapped read answered.");
  AST_HIT: assert property (
    file_rd_in && mapped |=> file_hit_out) else $error("Port read missed.");
  AST_NARROW: assert property (
    file_rd_in && file_addr_in == 5'h05 |=> file_rdata_out[7:4] == 4'h0)
    else $error("Narrow port high bits set.");
  AST_DIR: assert property (
    dl1 |=> wide_one_pin_bit_oe_out == ~$past(accum_in))
    else $error("Direction load wrong.");
  AST_NARROW_DIR: assert property (
    direction_load_op_in && direction_sel_in == 5'h05 |=>
    narrow_port_pins_oe_out == ~$past(accum_in[3:0]))
    else $error("Narrow direction load wrong.");
  AST_DIR_HOLD: assert property (
    !dl1 |=> $stable(wide_one_pin_bit_oe_out)) else $error("Direction moved.");
  AST_PIN_READ: assert property (
    $stable(wide_one_pin_bit_in)[*3] ##0 (file_rd_in && file_addr_in == 5'h06)
    |=> file_rdata_out == $past(wide_one_pin_bit_in))
    else $error("Read does not show pins.");
  cover property (dl1);
  cover property (file_rd_in && file_addr_in == 5'h05);
  cover property (file_rd_in && !mapped);
endmodule
bind bio_ports bio_ports_monitor bio_ports_monitor_inst (.sys_clk_in,
  .sys_rst_in, .file_addr_in, .file_rd_in, .direction_load_op_in,
  .direction_sel_in, .accum_in, .file_hit_out, .file_rdata_out,
  .narrow_port_pins_oe_out, .wide_one_pin_bit_in, .wide_one_pin_bit_oe_out,
  .wide_two_pin_bit_oe_out);

// ### bidirectional_io_ports_tb.sv
// Self-checking bench for the I/O port block.
`timescale 1ns/1ps
// ****
// Bench
// ****
module bidirectional_io_ports_tb;
  import bio_port_pkg::*;
  logic sys_clk_in, sys_rst_in, file_rd_in, file_wr_in, direction_load_op_in;
  logic file_hit_out;
  bio_addr_t file_addr_in, direction_sel_in;
  bio_byte_t file_wdata_in, accum_in, file_rdata_out, ext1, ext2;
  bio_byte_t wide_one_pin_bit_out, wide_one_pin_bit_oe_out;
  bio_byte_t wide_two_pin_bit_out, wide_two_pin_bit_oe_out;
  bio_byte_t st_rdata, st_oe2;
  bio_nib_t narrow_port_pins_out, narrow_port_pins_oe_out, ext0;
  wire bio_nib_t narrow_port_pins_in;
  wire bio_byte_t wide_one_pin_bit_in, wide_two_pin_bit_in;
  int failures, checks_done;
  bio_ports #(.WIDE_TWO_IS_PORT(1'b1)) bio_ports_inst (.sys_clk_in,
    .sys_rst_in, .file_addr_in, .file_rd_in, .file_wr_in, .file_wdata_in,
    .direction_load_op_in, .direction_sel_in, .accum_in, .file_hit_out,
    .file_rdata_out, .narrow_port_pins_in, .narrow_port_pins_out,
    .narrow_port_pins_oe_out, .wide_one_pin_bit_in, .wide_one_pin_bit_out,
    .wide_one_pin_bit_oe_out, .wide_two_pin_bit_in, .wide_two_pin_bit_out,
    .wide_two_pin_bit_oe_out);
  bio_ext_model bio_ext_model_inst (.ext_in({ext0, ext1, ext2}),
    .dev_in({narrow_port_pins_out, wide_one_pin_bit_out, wide_two_pin_bit_out}),
    .oe_in({narrow_port_pins_oe_out, wide_one_pin_bit_oe_out,
    wide_two_pin_bit_oe_out}), .level_out({narrow_port_pins_in,
    wide_one_pin_bit_in, wide_two_pin_bit_in}));
  // Second copy built as plain storage behind the last address.
  if (1'b1) begin : storage_variant
    bio_ports #(.WIDE_TWO_IS_PORT(1'b0)) bio_ports_inst (.sys_clk_in,
      .sys_rst_in, .file_addr_in, .file_rd_in, .file_wr_in, .file_wdata_in,
      .direction_load_op_in, .direction_sel_in, .accum_in, .file_hit_out(),
      .file_rdata_out(st_rdata), .narrow_port_pins_in,
      .narrow_port_pins_out(), .narrow_port_pins_oe_out(),
      .wide_one_pin_bit_in, .wide_one_pin_bit_out(),
      .wide_one_pin_bit_oe_out(), .wide_two_pin_bit_in(ext2),
      .wide_two_pin_bit_out(), .wide_two_pin_bit_oe_out(st_oe2));
  end
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input bio_byte_t got, input bio_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge sys_clk_in);
    #2;
  endtask
  task automatic acc_wr(input bio_addr_t a, input bio_byte_t d);
    step;
    {file_wr_in, file_addr_in, file_wdata_in} = {1'b1, a, d};
    step;
    file_wr_in = 1'b0;
  endtask
  task automatic acc_dl(input bio_addr_t s, input bio_byte_t v);
    step;
    {direction_load_op_in, direction_sel_in, accum_in} = {1'b1, s, v};
    step;
    direction_load_op_in = 1'b0;
  endtask
  // Pins settle through the input flops before the read strobe.
  task automatic acc_rd(input bio_addr_t a, input bio_byte_t exp);
    repeat (3) step;
    {file_rd_in, file_addr_in} = {1'b1, a};
    step;
    file_rd_in = 1'b0;
    chk(file_rdata_out, exp);
  endtask
  task automatic sc_drive;
    chk(wide_one_pin_bit_oe_out | wide_two_pin_bit_oe_out, 8'h00);
    chk({4'h0, narrow_port_pins_oe_out}, 8'h00);
    acc_dl(5'h06, 8'h00);
    chk(wide_one_pin_bit_oe_out, 8'hff);
    acc_wr(5'h06, 8'ha5);
    chk(wide_one_pin_bit_out, 8'ha5);
    acc_rd(5'h06, 8'ha5);
    chk({7'h00, file_hit_out}, 8'h01);
  endtask
  task automatic sc_mixed;
    ext1 = 8'h3c;
    acc_dl(5'h06, 8'h0f);
    chk(wide_one_pin_bit_oe_out, 8'hf0);
    chk(wide_one_pin_bit_out, 8'ha5);
    acc_rd(5'h06, (8'ha5 & 8'hf0) | (8'h3c & 8'h0f));
    acc_wr(5'h06, file_rdata_out);
    chk(wide_one_pin_bit_out, 8'hac);
  endtask
  task automatic sc_narrow;
    ext0 = 4'h3;
    acc_wr(5'h05, 8'hff);
    chk({4'h0, narrow_port_pins_out}, 8'h0f);
    acc_rd(5'h05, 8'h03);
    acc_dl(5'h05, 8'h00);
    chk({4'h0, narrow_port_pins_oe_out}, 8'h0f);
    chk(wide_one_pin_bit_oe_out, 8'hf0);
    acc_rd(5'h05, 8'h0f);
  endtask
  task automatic sc_wide_two;
    acc_wr(5'h07, 8'h5a);
    acc_dl(5'h07, 8'h00);
    chk(st_oe2, 8'h00);
    chk(wide_two_pin_bit_out, 8'h5a);
    acc_rd(5'h07, 8'h5a);
    chk(st_rdata, 8'h5a);
  endtask
  task automatic sc_unmapped;
    acc_wr(5'h08, 8'hff);
    acc_rd(5'h08, 8'h00);
    chk({7'h00, file_hit_out}, 8'h00);
    chk(wide_one_pin_bit_out, 8'hac);
  endtask
  task automatic sc_rereset;
    sys_rst_in = 1'b1;
    repeat (2) step;
    sys_rst_in = 1'b0;
    chk(wide_one_pin_bit_out, 8'hac);
    chk(wide_one_pin_bit_oe_out, 8'h00);
  endtask
  task automatic complete_run;
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {sys_rst_in, file_rd_in, file_wr_in, direction_load_op_in} = 4'h8;
    {file_addr_in, direction_sel_in, file_wdata_in, accum_in} = 26'h0;
    {ext0, ext1, ext2} = 20'h00099;
    failures = 0;
    checks_done = 0;
    repeat (6) step;
    sys_rst_in = 1'b0;
    sc_drive;
    sc_mixed;
    sc_narrow;
    sc_wide_two;
    sc_unmapped;
    sc_rereset;
    complete_run;
  end
endmodule
